// ### hdl/cmc_params.svh
// constants for the charger mode controller: register indexes, fields, resets, timing
// Functional notes
// - no source: internal current source off, rail fed from battery via FET.
// - source, FET open, charging enabled: hardware control mode, rail at preset or follower.
// - internal-path end-of-charge is detected and handled by the device alone.
// - FET closed and enabled: charge via external transistor, host decides end-of-charge.
// - FET opened after cycle: rail kept 150 or 300 mV above battery, no charging.
// - load beyond source with FET open after charging: FET closes automatically.
// - FET-on bit 0 at 0x26 closes FET when source present and charging allowed.
// - FET open, charging disabled: power-path; overload moves to reverse mode.
// - second input path enabled only by host setting bit 0 at 0x01.
// - below trickle threshold: low preset current, FET forced off, trickle watchdog started.
// - internal-path constant current set by bits 3:0 at 0x05, FET off.
// - hardware mode runs constant-current safety timer; software mode host kicks it.
// - reduced constant-current option, bits 2-1 at 0x0a, off by default.
// - external path current limit 2 A when 0x01 bit 0 is 1, else 4 A.
// - constant-voltage only on direct path with FET on and converter charging.
// - constant-voltage ends on end-of-charge current or watchdog; software may disable watchdog.
// - automatic end-of-charge raises battery-full interrupt when constant-voltage completes.
// - overshoot protection, 0x28 bit 0, keeps converter running during constant voltage.
// - FET-on set: interrupt host on constant-voltage entry; host stops via 0x01 bit 2.
// - FET-on left 0: device switches to direct path at threshold in 0x23 bits 4:0.
// - charge enable input active low; any disabling request wins.
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH

// register indexes; byte address is four times the index
`define CMC_IDX_CTRL 8'h01
`define CMC_IDX_CC 8'h05
`define CMC_IDX_RCC 8'h0a
`define CMC_IDX_THR 8'h23
`define CMC_IDX_FET 8'h26
`define CMC_IDX_OVS 8'h28
`define CMC_IDX_STAT 8'h30
`define CMC_IDX_EVT 8'h31
`define CMC_IDX_CFG 8'h32
`define CMC_IDX_KICK 8'h33

// field positions
`define CMC_CTRL_SINGLE 0
`define CMC_CTRL_STOP 2
`define CMC_EVT_CV 0
`define CMC_EVT_FULL 1
`define CMC_EVT_ERR 2

// reset values
`define CMC_RST_CTRL 8'h00
`define CMC_RST_CC 4'h0
`define CMC_RST_RCC 2'h0
`define CMC_RST_THR 5'h10
`define CMC_RST_CFG 5'h00

// timing
`define CMC_CLK_MHZ 100
`define CMC_TICK_CYCLES (`CMC_CLK_MHZ * 1000)
`define CMC_TRICKLE_MS 1800000
`define CMC_CC_MS 7200000
`define CMC_CV_MS 3600000

`endif

// ### hdl/cmc_pkg.sv
// types shared by the charger mode controller
package cmc_pkg;
  typedef enum logic [1:0] {
    CMC_MODE_HW = 2'b00,
    CMC_MODE_DIRECT = 2'b01,
    CMC_MODE_PPATH = 2'b11,
    CMC_MODE_REVERSE = 2'b10
  } cmc_mode_t;

  typedef enum logic [2:0] {
    CMC_PH_IDLE = 3'b000,
    CMC_PH_TRICKLE = 3'b001,
    CMC_PH_CC = 3'b011,
    CMC_PH_CV = 3'b010,
    CMC_PH_DONE = 3'b110,
    CMC_PH_ERROR = 3'b111
  } cmc_phase_t;

  typedef struct packed {
    logic source_present;
    logic below_trickle;
    logic [4:0] batt_level;
    logic cv_reached;
    logic eoc_current;
    logic load_over_source;
  } cmc_sense_t;

  typedef struct packed {
    logic fet_on;
    logic int_src_on;
    logic int_src_trickle;
    logic dcdc_on;
    logic second_path_en;
    logic ilim_4a;
    logic dcdc_keep_on;
    logic vsys_follower;
    logic follower_300mv;
    logic [1:0] vsys_preset;
    logic [3:0] cc_code;
    logic [1:0] cc_reduce;
  } cmc_drive_t;
endpackage

// ### hdl/cmc_wdog.sv
// millisecond watchdog: restarts on clear, counts while run, flags expiry
`timescale 1ns/100ps
`default_nettype none
module cmc_wdog #(
  parameter int TICK_CYCLES = 100000,
  parameter int LIMIT_MS = 1000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic restart,
  // status
  output logic expired
);
  logic [31:0] tick_reg;
  logic [31:0] ms_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n || restart || !run) begin
      tick_reg <= 32'h0;
    end else if (tick_reg == 32'(TICK_CYCLES - 1)) begin
      tick_reg <= 32'h0;
    end else begin
      tick_reg <= tick_reg + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || restart) begin
      ms_reg <= 32'h0;
      expired <= 1'b0;
    end else if (run && tick_reg == 32'(TICK_CYCLES - 1)) begin
      ms_reg <= ms_reg + 32'h1;
      expired <= expired | (ms_reg + 32'h1 >= 32'(LIMIT_MS));
    end
  end
endmodule
`default_nettype wire

// ### hdl/cmc_apb_if.sv
// apb slave handshake: one wait state, registered answer
`timescale 1ns/100ps
`default_nettype none
module cmc_apb_if (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // register side
  output logic [7:0] reg_index,
  output logic wr_en,
  input wire logic [31:0] rd_value,
  input wire logic addr_ok
);
  logic access;
  logic addr_good;

  assign access = psel && penable;
  assign reg_index = paddr[9:2];
  // an out-of-range or misaligned address must not alias onto a real register
  assign addr_good = addr_ok && paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0;
  // write lands only at the edge where pready is sampled high
  assign wr_en = access && pready && pwrite && addr_good;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0 : rd_value;
      pslverr <= !addr_good;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### hdl/cmc_top.sv
// charger mode controller: mode selection, charge phases, watchdogs, apb registers
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "cmc_params.svh"
module cmc_top #(
  parameter int TICK_CYCLES = `CMC_TICK_CYCLES,
  parameter int TRICKLE_MS = `CMC_TRICKLE_MS,
  parameter int CC_MS = `CMC_CC_MS,
  parameter int CV_MS = `CMC_CV_MS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // analog status and pins
  input wire cmc_pkg::cmc_sense_t sense,
  input wire logic charge_enable_n,
  // power stage controls
  output cmc_pkg::cmc_drive_t drive,
  output cmc_pkg::cmc_mode_t mode,
  output cmc_pkg::cmc_phase_t phase,
  // host events
  output logic battery_full_irq,
  output logic cv_entry_irq,
  output logic charge_error
);
  // software registers
  logic [7:0] ctrl_reg;
  logic [3:0] cc_reg;
  logic [1:0] rcc_reg;
  logic [4:0] direct_switch_threshold_reg;
  logic fet_cmd_reg;
  logic ovs_reg;
  logic [4:0] cfg_reg;
  logic [2:0] evt_reg;
  logic [2:0] evt_next;

  // bus side
  logic [7:0] reg_index;
  logic wr_en;
  logic [31:0] rd_value;
  logic addr_ok;
  logic kick;

  // control state
  cmc_pkg::cmc_mode_t mode_next;
  cmc_pkg::cmc_phase_t phase_next;
  logic auto_direct_reg;
  logic charge_ok;
  logic sw_ctrl;
  logic cv_wdog_en;
  logic fet_path;
  logic trickle_exp;
  logic cc_exp;
  logic cv_exp;
  logic cv_enter;
  logic cv_finish;
  logic wd_err;
  cmc_pkg::cmc_drive_t drive_next;

  assign sw_ctrl = cfg_reg[0];
  assign cv_wdog_en = !sw_ctrl || cfg_reg[1];

  // disabling from pin or register always wins
  assign charge_ok = !charge_enable_n && !ctrl_reg[`CMC_CTRL_STOP];

  // direct path: host command or autonomous threshold crossing
  assign fet_path = fet_cmd_reg || auto_direct_reg;

  cmc_apb_if u_apb (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .reg_index(reg_index),
    .wr_en(wr_en),
    .rd_value(rd_value),
    .addr_ok(addr_ok)
  );

  // register read mux and decode
  always_comb begin
    addr_ok = 1'b1;
    rd_value = 32'h0;
    if (reg_index == `CMC_IDX_CTRL) begin
      rd_value = {24'h0, ctrl_reg};
    end else if (reg_index == `CMC_IDX_CC) begin
      rd_value = {28'h0, cc_reg};
    end else if (reg_index == `CMC_IDX_RCC) begin
      rd_value = {29'h0, rcc_reg, 1'b0};
    end else if (reg_index == `CMC_IDX_THR) begin
      rd_value = {27'h0, direct_switch_threshold_reg};
    end else if (reg_index == `CMC_IDX_FET) begin
      rd_value = {31'h0, fet_cmd_reg};
    end else if (reg_index == `CMC_IDX_OVS) begin
      rd_value = {31'h0, ovs_reg};
    end else if (reg_index == `CMC_IDX_STAT) begin
      rd_value = {24'h0, auto_direct_reg, drive.fet_on, 1'b0, phase, mode};
    end else if (reg_index == `CMC_IDX_EVT) begin
      rd_value = {29'h0, evt_reg};
    end else if (reg_index == `CMC_IDX_CFG) begin
      rd_value = {27'h0, cfg_reg};
    end else if (reg_index == `CMC_IDX_KICK) begin
      rd_value = 32'h0;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign kick = wr_en && reg_index == `CMC_IDX_KICK;

  // control register, second path enable and stop bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= `CMC_RST_CTRL;
    end else if (wr_en && reg_index == `CMC_IDX_CTRL) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // internal-path current settings
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cc_reg <= `CMC_RST_CC;
      rcc_reg <= `CMC_RST_RCC;
    end else if (wr_en && reg_index == `CMC_IDX_CC) begin
      cc_reg <= pwdata[3:0];
    end else if (wr_en && reg_index == `CMC_IDX_RCC) begin
      rcc_reg <= pwdata[2:1];
    end
  end

  // threshold, overshoot option and configuration
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      direct_switch_threshold_reg <= `CMC_RST_THR;
      ovs_reg <= 1'b0;
      cfg_reg <= `CMC_RST_CFG;
    end else if (wr_en && reg_index == `CMC_IDX_THR) begin
      direct_switch_threshold_reg <= pwdata[4:0];
    end else if (wr_en && reg_index == `CMC_IDX_OVS) begin
      ovs_reg <= pwdata[0];
    end else if (wr_en && reg_index == `CMC_IDX_CFG) begin
      cfg_reg <= pwdata[4:0];
    end
  end

  // fet-on command; cleared at reset so boot starts in hardware control
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fet_cmd_reg <= 1'b0;
    end else if (wr_en && reg_index == `CMC_IDX_FET) begin
      fet_cmd_reg <= pwdata[0];
    end
  end

  // autonomous switch to the direct path once the battery crosses the threshold
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      auto_direct_reg <= 1'b0;
    end else if (!sense.source_present || !charge_ok || fet_cmd_reg) begin
      auto_direct_reg <= 1'b0;
    end else if (phase == cmc_pkg::CMC_PH_CC && sense.batt_level >= direct_switch_threshold_reg) begin
      auto_direct_reg <= 1'b1;
    end
  end

  // mode selection
  always_comb begin
    mode_next = cmc_pkg::CMC_MODE_PPATH;
    if (!sense.source_present) begin
      mode_next = cmc_pkg::CMC_MODE_REVERSE;
    end else if (charge_ok && phase != cmc_pkg::CMC_PH_DONE && phase != cmc_pkg::CMC_PH_ERROR) begin
      if (fet_path && !sense.below_trickle) begin
        mode_next = cmc_pkg::CMC_MODE_DIRECT;
      end else begin
        mode_next = cmc_pkg::CMC_MODE_HW;
      end
    end else if (sense.load_over_source) begin
      // battery takes the excess load without host help
      mode_next = cmc_pkg::CMC_MODE_REVERSE;
    end else begin
      mode_next = cmc_pkg::CMC_MODE_PPATH;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode <= cmc_pkg::CMC_MODE_HW;
    end else begin
      mode <= mode_next;
    end
  end

  // charge phase sequencing
  // judged on the next mode so the fet is never dropped while the phase is constant voltage
  assign cv_enter = phase == cmc_pkg::CMC_PH_CC && mode_next == cmc_pkg::CMC_MODE_DIRECT && sense.cv_reached;
  // with the host in charge of the fet, end-of-charge is the host's stop bit
  assign cv_finish = (sense.eoc_current && !fet_cmd_reg) || (cv_exp && cv_wdog_en);
  assign wd_err = (phase == cmc_pkg::CMC_PH_TRICKLE && trickle_exp) || (phase == cmc_pkg::CMC_PH_CC && cc_exp);

  always_comb begin
    phase_next = phase;
    if (!sense.source_present || !charge_ok) begin
      phase_next = cmc_pkg::CMC_PH_IDLE;
    end else begin
      case (phase)
        cmc_pkg::CMC_PH_IDLE: begin
          phase_next = sense.below_trickle ? cmc_pkg::CMC_PH_TRICKLE : cmc_pkg::CMC_PH_CC;
        end
        cmc_pkg::CMC_PH_TRICKLE: begin
          if (wd_err) begin
            phase_next = cmc_pkg::CMC_PH_ERROR;
          end else if (!sense.below_trickle) begin
            phase_next = cmc_pkg::CMC_PH_CC;
          end
        end
        cmc_pkg::CMC_PH_CC: begin
          if (wd_err) begin
            phase_next = cmc_pkg::CMC_PH_ERROR;
          end else if (cv_enter) begin
            phase_next = cmc_pkg::CMC_PH_CV;
          end else if (mode == cmc_pkg::CMC_MODE_HW && !fet_path && sense.eoc_current) begin
            phase_next = cmc_pkg::CMC_PH_DONE;
          end
        end
        cmc_pkg::CMC_PH_CV: begin
          if (mode_next != cmc_pkg::CMC_MODE_DIRECT) begin
            phase_next = cmc_pkg::CMC_PH_CC;
          end else if (cv_finish) begin
            phase_next = cmc_pkg::CMC_PH_DONE;
          end
        end
        cmc_pkg::CMC_PH_DONE: begin
          phase_next = cmc_pkg::CMC_PH_DONE;
        end
        default: begin
          phase_next = cmc_pkg::CMC_PH_ERROR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase <= cmc_pkg::CMC_PH_IDLE;
    end else begin
      phase <= phase_next;
    end
  end

  // watchdogs: trickle, constant current (kicked by host in software mode), constant voltage
  cmc_wdog #(.TICK_CYCLES(TICK_CYCLES), .LIMIT_MS(TRICKLE_MS)) u_wd_trickle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(phase == cmc_pkg::CMC_PH_TRICKLE),
    .restart(phase != cmc_pkg::CMC_PH_TRICKLE),
    .expired(trickle_exp)
  );

  cmc_wdog #(.TICK_CYCLES(TICK_CYCLES), .LIMIT_MS(CC_MS)) u_wd_cc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(phase == cmc_pkg::CMC_PH_CC),
    .restart(phase != cmc_pkg::CMC_PH_CC || (sw_ctrl && kick)),
    .expired(cc_exp)
  );

  cmc_wdog #(.TICK_CYCLES(TICK_CYCLES), .LIMIT_MS(CV_MS)) u_wd_cv (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(phase == cmc_pkg::CMC_PH_CV && cv_wdog_en),
    .restart(phase != cmc_pkg::CMC_PH_CV),
    .expired(cv_exp)
  );

  // sticky events; a new event wins over a same-cycle write-one clear
  always_comb begin
    evt_next = evt_reg;
    if (wr_en && reg_index == `CMC_IDX_EVT) begin
      evt_next = evt_reg & ~pwdata[2:0];
    end
    if (phase != cmc_pkg::CMC_PH_CV && phase_next == cmc_pkg::CMC_PH_CV && fet_cmd_reg) begin
      evt_next[`CMC_EVT_CV] = 1'b1;
    end
    if (phase == cmc_pkg::CMC_PH_CV && phase_next == cmc_pkg::CMC_PH_DONE && !fet_cmd_reg) begin
      evt_next[`CMC_EVT_FULL] = 1'b1;
    end
    if (phase != cmc_pkg::CMC_PH_ERROR && phase_next == cmc_pkg::CMC_PH_ERROR) begin
      evt_next[`CMC_EVT_ERR] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      evt_reg <= 3'h0;
      cv_entry_irq <= 1'b0;
      battery_full_irq <= 1'b0;
      charge_error <= 1'b0;
    end else begin
      evt_reg <= evt_next;
      cv_entry_irq <= evt_next[`CMC_EVT_CV];
      battery_full_irq <= evt_next[`CMC_EVT_FULL];
      charge_error <= evt_next[`CMC_EVT_ERR];
    end
  end

  // power stage drive, derived from the next mode and phase so outputs track the state registers
  always_comb begin
    drive_next = '0;
    drive_next.fet_on = mode_next == cmc_pkg::CMC_MODE_DIRECT || mode_next == cmc_pkg::CMC_MODE_REVERSE;
    if (phase_next == cmc_pkg::CMC_PH_TRICKLE) begin
      drive_next.fet_on = 1'b0;
    end
    drive_next.int_src_on = mode_next == cmc_pkg::CMC_MODE_HW &&
      (phase_next == cmc_pkg::CMC_PH_TRICKLE || phase_next == cmc_pkg::CMC_PH_CC);
    drive_next.int_src_trickle = phase_next == cmc_pkg::CMC_PH_TRICKLE;
    drive_next.dcdc_on = mode_next == cmc_pkg::CMC_MODE_DIRECT;
    drive_next.second_path_en = sense.source_present && ctrl_reg[`CMC_CTRL_SINGLE];
    drive_next.ilim_4a = !ctrl_reg[`CMC_CTRL_SINGLE];
    // keeping the converter switching lets it catch falling load steps before the battery overshoots
    drive_next.dcdc_keep_on = ovs_reg && phase_next == cmc_pkg::CMC_PH_CV;
    drive_next.vsys_follower = cfg_reg[2] || mode_next == cmc_pkg::CMC_MODE_PPATH;
    drive_next.follower_300mv = cfg_reg[3];
    drive_next.vsys_preset = {cfg_reg[4], cfg_reg[1] & sw_ctrl};
    drive_next.cc_code = cc_reg;
    drive_next.cc_reduce = rcc_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      drive <= '0;
    end else begin
      drive <= drive_next;
    end
  end
endmodule
`default_nettype wire

// ### testbench/cmc_top_props.sv
// port assertions for the charger mode controller
`timescale 1ns/100ps
`default_nettype none
module cmc_top_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // sense and outputs
  input wire cmc_pkg::cmc_sense_t sense,
  input wire logic charge_enable_n,
  input wire cmc_pkg::cmc_drive_t drive,
  input wire cmc_pkg::cmc_mode_t mode,
  input wire cmc_pkg::cmc_phase_t phase,
  input wire logic battery_full_irq,
  input wire logic cv_entry_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("answer not one cycle after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("answer held too long");
  property p_quiet; (pslverr || prdata != 32'h0) |-> pready; endproperty
  a_quiet: assert property (p_quiet) else $error("read data or error outside answer");
  property p_nosrc; !sense.source_present |=> mode == cmc_pkg::CMC_MODE_REVERSE && !drive.int_src_on; endproperty
  a_nosrc: assert property (p_nosrc) else $error("not in reverse without source");
  property p_trk; phase == cmc_pkg::CMC_PH_TRICKLE |-> !drive.fet_on && drive.int_src_trickle; endproperty
  a_trk: assert property (p_trk) else $error("trickle with fet on");
  property p_cv; phase == cmc_pkg::CMC_PH_CV |-> drive.fet_on && drive.dcdc_on; endproperty
  a_cv: assert property (p_cv) else $error("constant voltage off the direct path");
  property p_dis; charge_enable_n |=> !drive.int_src_on; endproperty
  a_dis: assert property (p_dis) else $error("charging while disabled");
  property p_full; $rose(battery_full_irq) |-> phase == cmc_pkg::CMC_PH_DONE; endproperty
  a_full: assert property (p_full) else $error("full event without completion");
  property p_cvirq; $rose(cv_entry_irq) |-> phase == cmc_pkg::CMC_PH_CV && drive.fet_on; endproperty
  a_cvirq: assert property (p_cvirq) else $error("cv event without cv entry");
  c_cv: cover property (phase == cmc_pkg::CMC_PH_CV);
  c_full: cover property (battery_full_irq);
  c_err: cover property (pslverr && pready);
endmodule
bind cmc_top cmc_top_props u_props (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .sense(sense), .charge_enable_n(charge_enable_n),
  .drive(drive), .mode(mode), .phase(phase), .battery_full_irq(battery_full_irq), .cv_entry_irq(cv_entry_irq));
`default_nettype wire

// ### testbench/cmc_batt_model.sv
// battery and source model feeding the sense inputs
`timescale 1ns/100ps
`default_nettype none
module cmc_batt_model #(
  parameter int TRICKLE_LVL = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bench knobs
  input wire logic plug,
  input wire logic [4:0] level,
  input wire logic eoc,
  input wire logic overload,
  // sensed levels
  output cmc_pkg::cmc_sense_t sense
);
  // comparators land a cycle late, as the real sensing path does
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sense <= '0;
    end else begin
      sense.source_present <= plug;
      sense.below_trickle <= level < 5'(TRICKLE_LVL);
      sense.batt_level <= level;
      sense.cv_reached <= level == 5'h1f;
      sense.eoc_current <= eoc && level == 5'h1f;
      sense.load_over_source <= overload && plug;
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_charger_mode_controller.sv
// self-checking bench for the charger mode controller
`timescale 1ns/100ps
`default_nettype none
`include "cmc_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module tb_charger_mode_controller;
  localparam int TICK = 10;
  localparam int CV_MS = 10;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic pready, pslverr, battery_full_irq, cv_entry_irq, charge_error;
  logic plug = 0, eoc = 0, ovl = 0, charge_enable_n = 1;
  logic [4:0] lvl = '0;
  logic [31:0] seed = 32'ha14344d9;
  cmc_pkg::cmc_sense_t sense;
  cmc_pkg::cmc_drive_t drive;
  cmc_pkg::cmc_mode_t mode;
  cmc_pkg::cmc_phase_t phase;
  int bad_count = 0, n_tests = 0, mreg[256];
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  cmc_top #(.TICK_CYCLES(TICK), .TRICKLE_MS(20), .CC_MS(20), .CV_MS(CV_MS)) dut (.core_clk(core_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sense(sense), .charge_enable_n(charge_enable_n),
    .drive(drive), .mode(mode), .phase(phase), .battery_full_irq(battery_full_irq),
    .cv_entry_irq(cv_entry_irq), .charge_error(charge_error));
  cmc_batt_model u_batt (.core_clk(core_clk), .rst_n(rst_n), .plug(plug), .level(lvl), .eoc(eoc),
    .overload(ovl), .sense(sense));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one transfer; an edge passes first so back-to-back calls never reassign in one step
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) bad_count++;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] wd);
    apb(1'b1, ix, wd);
    if (ix == `CMC_IDX_EVT) mreg[ix] &= ~wd;
    else mreg[ix] = wd;
  endtask
  task automatic rdc(input logic [7:0] ix, input logic xerr);
    apb(1'b0, ix, '0);
    `CHK(er, xerr)
    `CHK(rd, xerr ? 32'h0 : 32'(mreg[ix]))
  endtask
  task automatic wph(input cmc_pkg::cmc_phase_t p, input int lim, output int n);
    n = 0;
    while (phase !== p && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(phase, p)
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    int n;
    logic [31:0] v;
    logic [7:0] idx [8];
    idx = '{`CMC_IDX_CTRL, `CMC_IDX_CC, `CMC_IDX_RCC, `CMC_IDX_THR, `CMC_IDX_FET, `CMC_IDX_OVS,
      `CMC_IDX_EVT, `CMC_IDX_CFG};
    mreg[`CMC_IDX_THR] = 32'h10;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(idx[i], 1'b0);
    wr(8'h02, rnd());
    rdc(8'h02, 1'b1);
    $display("test registers done");
    charge_enable_n <= 1'b0;
    plug <= 1'b1;
    lvl <= 5'h02;
    wph(cmc_pkg::CMC_PH_TRICKLE, 50, n);
    `CHK(mode, cmc_pkg::CMC_MODE_HW)
    v = rnd() & 32'hf;
    wr(`CMC_IDX_CC, v);
    wr(`CMC_IDX_RCC, rnd() & 32'h6);
    lvl <= 5'h04 + 5'(rnd() % 12);
    wph(cmc_pkg::CMC_PH_CC, 50, n);
    `CHK(drive.cc_code, v[3:0])
    `CHK(drive.cc_reduce, 2'(mreg[`CMC_IDX_RCC] >> 1))
    `CHK(drive.int_src_on, 1'b1)
    `CHK(drive.fet_on, 1'b0)
    `CHK(drive.second_path_en, 1'b0)
    lvl <= 5'h14;
    // sensing, threshold flop and mode flop: three edges, seen at the fourth
    repeat (4) @(posedge core_clk);
    `CHK(mode, cmc_pkg::CMC_MODE_DIRECT)
    `CHK(drive.fet_on, 1'b1)
    `CHK(drive.ilim_4a, 1'b1)
    lvl <= 5'h1f;
    wph(cmc_pkg::CMC_PH_CV, 20, n);
    eoc <= 1'b1;
    wph(cmc_pkg::CMC_PH_DONE, 20, n);
    `CHK(battery_full_irq, 1'b1)
    `CHK(cv_entry_irq, 1'b0)
    mreg[`CMC_IDX_EVT] = 2;
    rdc(`CMC_IDX_EVT, 1'b0);
    wr(`CMC_IDX_EVT, 32'h2);
    rdc(`CMC_IDX_EVT, 1'b0);
    `CHK(battery_full_irq, 1'b0)
    charge_enable_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(mode, cmc_pkg::CMC_MODE_PPATH)
    `CHK(phase, cmc_pkg::CMC_PH_IDLE)
    ovl <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(mode, cmc_pkg::CMC_MODE_REVERSE)
    plug <= 1'b0;
    ovl <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(mode, cmc_pkg::CMC_MODE_REVERSE)
    $display("test autonomous cycle done");
    plug <= 1'b1;
    eoc <= 1'b0;
    lvl <= 5'h0a;
    charge_enable_n <= 1'b0;
    wph(cmc_pkg::CMC_PH_CC, 50, n);
    wr(`CMC_IDX_FET, 32'h1);
    wr(`CMC_IDX_CTRL, 32'h1);
    wr(`CMC_IDX_OVS, 32'h1);
    `CHK(mode, cmc_pkg::CMC_MODE_DIRECT)
    `CHK(drive.fet_on, 1'b1)
    `CHK(drive.ilim_4a, 1'b0)
    `CHK(drive.second_path_en, 1'b1)
    lvl <= 5'h1f;
    wph(cmc_pkg::CMC_PH_CV, 20, n);
    `CHK(cv_entry_irq, 1'b1)
    `CHK(drive.dcdc_keep_on, 1'b1)
    eoc <= 1'b1;
    repeat (5) @(posedge core_clk);
    `CHK(phase, cmc_pkg::CMC_PH_CV)
    // the constant-voltage watchdog ends the phase like end-of-charge, not as an error
    wph(cmc_pkg::CMC_PH_DONE, CV_MS * TICK + 20, n);
    `CHK(n > CV_MS * TICK - 12, 1'b1)
    `CHK(charge_error, 1'b0)
    `CHK(battery_full_irq, 1'b0)
    wr(`CMC_IDX_CTRL, 32'h5);
    wph(cmc_pkg::CMC_PH_IDLE, 20, n);
    lvl <= 5'h02;
    wr(`CMC_IDX_CTRL, 32'h1);
    wph(cmc_pkg::CMC_PH_TRICKLE, 20, n);
    wph(cmc_pkg::CMC_PH_ERROR, 230, n);
    `CHK(n > 190, 1'b1)
    `CHK(charge_error, 1'b1)
    $display("test direct cycle done");
    give_verdict();
  end
endmodule
`default_nettype wire
